// ---- pkg/ies_pkg.sv ----
package ies_pkg;

   // widths and sources
   localparam int ERR_W = 4;
   localparam int RSP_W = 8;
   localparam int ERR_SRC = 2;

   // error codes held in the highest error register
   localparam logic [ERR_W-1:0] ERR_NONE = 4'h0;
   localparam logic [ERR_W-1:0] ERR_NOT_NOW = 4'h1;
   localparam logic [ERR_W-1:0] ERR_CONFIG = 4'h2;
   localparam logic [ERR_W-1:0] ERR_RANGE = 4'h3;
   localparam logic [ERR_W-1:0] ERR_SYNTAX = 4'h4;
   localparam logic [ERR_W-1:0] ERR_MISSING = 4'h5;
   localparam logic [ERR_W-1:0] ERR_EXTRA = 4'h6;
   localparam logic [ERR_W-1:0] ERR_BAD_CMD = 4'h7;
   localparam logic [ERR_W-1:0] ERR_TOO_LONG = 4'h8;
   localparam logic [ERR_W-1:0] ERR_RSP_UNREAD = 4'h9;
   localparam logic [ERR_W-1:0] ERR_RX_OVR = 4'ha;
   localparam logic [ERR_W-1:0] ERR_MAX = 4'ha;

   // event status byte positions, non-gpib format
   localparam int ESR_B_CMD_ERR = 0;
   localparam int ESR_B_TX_OVR = 1;
   // event status byte positions, gpib format
   localparam int ESR_B_OPC = 0;
   localparam int ESR_B_QUERY = 3;
   localparam int ESR_B_EXEC = 4;
   localparam int ESR_B_CMD = 5;
   localparam int ESR_B_PON = 7;

   // legacy error flag positions
   localparam int LEG_B_OK = 0;
   localparam int LEG_B_COUNT = 1;
   localparam int LEG_B_FIELD = 2;
   localparam int LEG_B_CONFIG = 3;
   localparam int LEG_B_TX_OVR = 4;
   localparam int LEG_B_RX_OVR = 5;
   localparam int LEG_B_UNKNOWN = 6;
   localparam logic [RSP_W-1:0] LEG_M_STICKY = 8'h7e;

   // status byte positions
   localparam int STB_B_MC = 0;
   localparam int STB_B_RSP = 4;
   localparam int STB_B_ESR = 5;
   localparam int STB_B_MSS = 6;

   // reset values
   localparam logic [RSP_W-1:0] ESR_RST = 8'h80;
   localparam logic [RSP_W-1:0] LEG_RST = 8'h00;
   localparam logic [RSP_W-1:0] ESE_RST = 8'h00;
   localparam logic [RSP_W-1:0] SRE_RST = 8'h00;
   localparam logic [RSP_W-1:0] MCE_RST = 8'h00;

   // fixed answers
   localparam logic [RSP_W-1:0] GPIB_LEG_ANSWER = 8'h01;
   localparam logic [RSP_W-1:0] TST_ANSWER = 8'h00;

   // commands handed over by the parser
   typedef enum logic [3:0] {
      CMD_CLEAR,
      CMD_ERR_Q,
      CMD_ESR_Q,
      CMD_LEG_Q,
      CMD_WAIT,
      CMD_ESE_SET,
      CMD_ESE_Q,
      CMD_OPC_SET,
      CMD_SRE_SET,
      CMD_SRE_Q,
      CMD_STB_Q,
      CMD_TST_Q,
      CMD_MCE_SET,
      CMD_MCE_Q
   } ies_cmd_t;

endpackage : ies_pkg

// ---- pkg/ies_err_if.sv ----
`timescale 1ns/1ns
interface ies_err_if;
   logic [ies_pkg::ERR_SRC-1:0] ev_valid;
   logic [ies_pkg::ERR_W-1:0] ev_code [ies_pkg::ERR_SRC];
   logic clr;
   logic [ies_pkg::ERR_W-1:0] code;

   modport ctl (output ev_valid, output ev_code, output clr, input code);
   modport acc (input ev_valid, input ev_code, input clr, output code);
endinterface : ies_err_if

// ---- hdl/ies_err_acc.sv ----
`timescale 1ns/1ns
module ies_err_acc (
   input logic i_clk, // system clock
   input logic i_rst_n, // async reset, active low
   ies_err_if.acc bus // events, clear and held code
);

   logic [ies_pkg::ERR_W-1:0] code;
   logic [ies_pkg::ERR_W-1:0] next_code;

   // keep the highest code, an event in the clearing cycle survives
   always_comb begin
      next_code = bus.clr ? ies_pkg::ERR_NONE : code;
      for (int i = 0; i < ies_pkg::ERR_SRC; i++) begin
         if (bus.ev_valid[i] && bus.ev_code[i] > next_code && bus.ev_code[i] <= ies_pkg::ERR_MAX) begin
            next_code = bus.ev_code[i];
         end
      end
   end

   // code register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         code <= ies_pkg::ERR_NONE;
      end else begin
         code <= next_code;
      end
   end

   assign bus.code = code;

endmodule : ies_err_acc

// ---- hdl/ies_regs.sv ----
`timescale 1ns/1ns
module ies_regs #(
   parameter int MC_W = 8 // measurement condition width
) (
   input logic i_clk, // system clock, 10 MHz
   input logic i_rst_n, // async reset, active low
   input logic i_cmd_valid, // command strobe, one cycle
   input ies_pkg::ies_cmd_t i_cmd, // decoded command
   input logic [ies_pkg::RSP_W-1:0] i_cmd_arg, // numeric field of set commands
   input logic i_cmd_gpib, // command came through gpib
   input logic i_tx_busy, // previous response still sending
   input logic i_err_valid, // parser error strobe
   input logic [ies_pkg::ERR_W-1:0] i_err_code, // parser error code
   input logic i_err_gpib, // parser error came through gpib
   input logic i_link_drop, // link disconnected or socket closed
   input logic i_gpib_en, // gpib interface enabled level
   input logic [MC_W-1:0] i_mcr, // measurement condition bits
   input logic i_rsp_ready, // a response waits to be read
   output logic o_rsp_valid, // answer strobe, one cycle
   output logic [ies_pkg::RSP_W-1:0] o_rsp_data, // answer value
   output logic o_err_indicate, // on-screen error indication
   output logic [ies_pkg::RSP_W-1:0] o_stb, // live status byte
   output logic o_srq, // gpib service request
   output logic o_tx_flush, // discard pending tx data, one cycle
   output logic o_go_local // return to local state, one cycle
);

   if (MC_W < 1 || MC_W > ies_pkg::RSP_W) begin : g_bad_mc_w
      $error("MC_W must lie between 1 and 8");
   end

   // event status bits raised by one error event
   function automatic logic [ies_pkg::RSP_W-1:0] esr_bits(
      input logic [ies_pkg::ERR_W-1:0] code,
      input logic gpib
   );
      logic [ies_pkg::RSP_W-1:0] m;
      m = 8'h00;
      if (!gpib) begin
         if (code == ies_pkg::ERR_RSP_UNREAD) begin
            m[ies_pkg::ESR_B_TX_OVR] = 1'b1;
         end else begin
            m[ies_pkg::ESR_B_CMD_ERR] = 1'b1;
         end
      end else begin
         unique case (code)
            ies_pkg::ERR_TOO_LONG, ies_pkg::ERR_RSP_UNREAD: m[ies_pkg::ESR_B_QUERY] = 1'b1;
            ies_pkg::ERR_NOT_NOW, ies_pkg::ERR_CONFIG,
            ies_pkg::ERR_RANGE, ies_pkg::ERR_RX_OVR: m[ies_pkg::ESR_B_EXEC] = 1'b1;
            ies_pkg::ERR_SYNTAX, ies_pkg::ERR_MISSING,
            ies_pkg::ERR_EXTRA, ies_pkg::ERR_BAD_CMD: m[ies_pkg::ESR_B_CMD] = 1'b1;
            default: m = 8'h00;
         endcase
      end
      return m;
   endfunction : esr_bits

   // legacy flag bits raised by one error event, b0 stored as error seen
   function automatic logic [ies_pkg::RSP_W-1:0] leg_bits(
      input logic [ies_pkg::ERR_W-1:0] code
   );
      logic [ies_pkg::RSP_W-1:0] m;
      m = 8'h00;
      unique case (code)
         ies_pkg::ERR_MISSING, ies_pkg::ERR_EXTRA: m[ies_pkg::LEG_B_COUNT] = 1'b1;
         ies_pkg::ERR_RANGE, ies_pkg::ERR_SYNTAX: m[ies_pkg::LEG_B_FIELD] = 1'b1;
         ies_pkg::ERR_CONFIG: m[ies_pkg::LEG_B_CONFIG] = 1'b1;
         ies_pkg::ERR_RSP_UNREAD: m[ies_pkg::LEG_B_TX_OVR] = 1'b1;
         ies_pkg::ERR_RX_OVR: m[ies_pkg::LEG_B_RX_OVR] = 1'b1;
         ies_pkg::ERR_BAD_CMD: m[ies_pkg::LEG_B_UNKNOWN] = 1'b1;
         default: m = 8'h00;
      endcase
      m[ies_pkg::LEG_B_OK] = 1'b1;
      return m;
   endfunction : leg_bits

   ies_err_if err_bus ();

   logic [ies_pkg::RSP_W-1:0] event_status_byte;
   logic [ies_pkg::RSP_W-1:0] leg;
   logic [ies_pkg::RSP_W-1:0] event_status_enable;
   logic [ies_pkg::RSP_W-1:0] service_request_enable;
   logic [MC_W-1:0] measurement_condition_enable;
   logic gpib_en_d;
   logic rsp_valid;
   logic [ies_pkg::RSP_W-1:0] rsp_data;
   logic tx_flush;
   logic go_local;

   // command decode
   wire is_clear = i_cmd == ies_pkg::CMD_CLEAR;
   wire is_err_q = i_cmd == ies_pkg::CMD_ERR_Q;
   wire is_esr_q = i_cmd == ies_pkg::CMD_ESR_Q;
   wire is_leg_q = i_cmd == ies_pkg::CMD_LEG_Q;
   wire is_ese_set = i_cmd == ies_pkg::CMD_ESE_SET;
   wire is_ese_q = i_cmd == ies_pkg::CMD_ESE_Q;
   wire is_opc_set = i_cmd == ies_pkg::CMD_OPC_SET;
   wire is_sre_set = i_cmd == ies_pkg::CMD_SRE_SET;
   wire is_sre_q = i_cmd == ies_pkg::CMD_SRE_Q;
   wire is_stb_q = i_cmd == ies_pkg::CMD_STB_Q;
   wire is_tst_q = i_cmd == ies_pkg::CMD_TST_Q;
   wire is_mce_set = i_cmd == ies_pkg::CMD_MCE_SET;
   wire is_mce_q = i_cmd == ies_pkg::CMD_MCE_Q;
   wire is_wait = i_cmd == ies_pkg::CMD_WAIT;

   // command classes
   wire is_query = is_err_q | is_esr_q | is_leg_q | is_ese_q | is_sre_q | is_stb_q | is_tst_q | is_mce_q;
   wire gpib_only = is_wait | is_ese_set | is_ese_q | is_opc_set | is_sre_set | is_sre_q
      | is_stb_q | is_tst_q | is_mce_set | is_mce_q;

   // refusal and overrun checks
   wire cmd_refused = i_cmd_valid & gpib_only & ~i_cmd_gpib;
   wire tx_overrun = i_cmd_valid & is_query & i_tx_busy & ~cmd_refused;
   wire cmd_ok = i_cmd_valid & ~cmd_refused & ~tx_overrun;
   wire do_clear = cmd_ok & is_clear;
   wire int_err_valid = cmd_refused | tx_overrun;
   wire [ies_pkg::ERR_W-1:0] int_err_code = cmd_refused ? ies_pkg::ERR_BAD_CMD : ies_pkg::ERR_RSP_UNREAD;

   // feed both error sources into the highest-code register
   assign err_bus.ev_valid = {int_err_valid, i_err_valid};
   assign err_bus.ev_code[0] = i_err_code;
   assign err_bus.ev_code[1] = int_err_code;
   assign err_bus.clr = (cmd_ok & is_err_q) | i_link_drop | do_clear;

   ies_err_acc u_err_acc (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .bus(err_bus)
   );

   // event status sets from errors, opc and gpib power-up edge
   wire ext_in_range = i_err_valid & (i_err_code != ies_pkg::ERR_NONE) & (i_err_code <= ies_pkg::ERR_MAX);
   wire [ies_pkg::RSP_W-1:0] ext_esr = ext_in_range ? esr_bits(i_err_code, i_err_gpib) : 8'h00;
   wire [ies_pkg::RSP_W-1:0] int_esr = int_err_valid ? esr_bits(int_err_code, i_cmd_gpib) : 8'h00;
   wire [ies_pkg::RSP_W-1:0] opc_esr = (cmd_ok & is_opc_set) ? (8'h01 << ies_pkg::ESR_B_OPC) : 8'h00;
   wire gpib_rise = i_gpib_en & ~gpib_en_d;
   wire [ies_pkg::RSP_W-1:0] pon_esr = gpib_rise ? (8'h01 << ies_pkg::ESR_B_PON) : 8'h00;
   wire [ies_pkg::RSP_W-1:0] esr_set = ext_esr | int_esr | opc_esr | pon_esr;
   wire clr_esr = (cmd_ok & is_esr_q) | do_clear;
   wire [ies_pkg::RSP_W-1:0] next_esr = (clr_esr ? 8'h00 : event_status_byte) | esr_set;

   // legacy flags, recorded for non-gpib events only
   wire [ies_pkg::RSP_W-1:0] ext_leg = (ext_in_range & ~i_err_gpib) ? leg_bits(i_err_code) : 8'h00;
   wire [ies_pkg::RSP_W-1:0] int_leg = (int_err_valid & ~i_cmd_gpib) ? leg_bits(int_err_code) : 8'h00;
   wire clr_leg = (cmd_ok & is_leg_q) | do_clear;
   wire [ies_pkg::RSP_W-1:0] next_leg = (clr_leg ? 8'h00 : leg) | ext_leg | int_leg;

   // legacy read value: stored b0 marks an error seen, so it reads inverted
   wire leg_clean = ~leg[ies_pkg::LEG_B_OK];
   wire [ies_pkg::RSP_W-1:0] leg_read = (leg & ies_pkg::LEG_M_STICKY)
      | (leg_clean ? (8'h01 << ies_pkg::LEG_B_OK) : 8'h00);

   // enable registers written by set commands, wiped by clear
   wire [ies_pkg::RSP_W-1:0] next_ese = do_clear ? ies_pkg::ESE_RST
      : (cmd_ok & is_ese_set) ? i_cmd_arg : event_status_enable;
   wire [ies_pkg::RSP_W-1:0] next_sre = do_clear ? ies_pkg::SRE_RST
      : (cmd_ok & is_sre_set) ? i_cmd_arg : service_request_enable;
   wire [MC_W-1:0] next_mce = do_clear ? ies_pkg::MCE_RST[MC_W-1:0]
      : (cmd_ok & is_mce_set) ? i_cmd_arg[MC_W-1:0] : measurement_condition_enable;

   // status byte summary chain
   wire mc_hit = |(i_mcr & measurement_condition_enable);
   wire esr_hit = |(event_status_byte & event_status_enable);
   wire [ies_pkg::RSP_W-1:0] stb_req = (mc_hit ? (8'h01 << ies_pkg::STB_B_MC) : 8'h00)
      | (i_rsp_ready ? (8'h01 << ies_pkg::STB_B_RSP) : 8'h00)
      | (esr_hit ? (8'h01 << ies_pkg::STB_B_ESR) : 8'h00);
   wire mss = |(stb_req & service_request_enable);
   wire [ies_pkg::RSP_W-1:0] stb = stb_req | (mss ? (8'h01 << ies_pkg::STB_B_MSS) : 8'h00);

   // answer selection for queries
   wire [ies_pkg::RSP_W-1:0] mce_wide = {{(ies_pkg::RSP_W - MC_W){1'b0}}, measurement_condition_enable};
   wire [ies_pkg::RSP_W-1:0] leg_answer = i_cmd_gpib ? ies_pkg::GPIB_LEG_ANSWER : leg_read;
   wire [ies_pkg::RSP_W-1:0] next_rsp_data = is_err_q ? {4'h0, err_bus.code}
      : is_esr_q ? event_status_byte
      : is_leg_q ? leg_answer
      : is_ese_q ? event_status_enable
      : is_sre_q ? service_request_enable
      : is_stb_q ? stb
      : is_mce_q ? mce_wide
      : ies_pkg::TST_ANSWER;
   wire rsp_fire = cmd_ok & is_query;

   // status register updates
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         event_status_byte <= ies_pkg::ESR_RST;
         leg <= ies_pkg::LEG_RST;
      end else begin
         event_status_byte <= next_esr;
         leg <= next_leg;
      end
   end

   // enable register updates
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         event_status_enable <= ies_pkg::ESE_RST;
         service_request_enable <= ies_pkg::SRE_RST;
         measurement_condition_enable <= ies_pkg::MCE_RST[MC_W-1:0];
      end else begin
         event_status_enable <= next_ese;
         service_request_enable <= next_sre;
         measurement_condition_enable <= next_mce;
      end
   end

   // gpib enable history for the power-on edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gpib_en_d <= 1'b0;
      end else begin
         gpib_en_d <= i_gpib_en;
      end
   end

   // answer register, data held until the next answer
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
      end else begin
         rsp_valid <= rsp_fire;
         if (rsp_fire) begin
            rsp_data <= next_rsp_data;
         end
      end
   end

   // clear side effects towards transmit path and panel
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_flush <= 1'b0;
         go_local <= 1'b0;
      end else begin
         tx_flush <= do_clear;
         go_local <= do_clear;
      end
   end

   // outputs
   assign o_rsp_valid = rsp_valid;
   assign o_rsp_data = rsp_data;
   assign o_err_indicate = err_bus.code != ies_pkg::ERR_NONE;
   assign o_stb = stb;
   assign o_srq = mss;
   assign o_tx_flush = tx_flush;
   assign o_go_local = go_local;

endmodule : ies_regs

// ---- tb/ies_regs_checker.sv ----
`timescale 1ns/1ns
module ies_regs_checker #(
   parameter int MC_W = 8 // condition width
) (
   input wire logic i_clk, // clock
   input wire logic i_rst_n, // reset
   input wire logic i_cmd_valid, // cmd strobe
   input wire ies_pkg::ies_cmd_t i_cmd, // command
   input wire logic [ies_pkg::RSP_W-1:0] i_cmd_arg, // argument
   input wire logic i_cmd_gpib, // cmd via gpib
   input wire logic i_tx_busy, // tx busy
   input wire logic i_err_valid, // err strobe
   input wire logic [ies_pkg::ERR_W-1:0] i_err_code, // err code
   input wire logic i_err_gpib, // err via gpib
   input wire logic i_link_drop, // link drop
   input wire logic i_gpib_en, // gpib enabled
   input wire logic [MC_W-1:0] i_mcr, // conditions
   input wire logic i_rsp_ready, // rsp ready
   input wire logic o_rsp_valid, // answer strobe
   input wire logic [ies_pkg::RSP_W-1:0] o_rsp_data, // answer
   input wire logic o_err_indicate, // indication
   input wire logic [ies_pkg::RSP_W-1:0] o_stb, // status byte
   input wire logic o_srq, // service request
   input wire logic o_tx_flush, // flush pulse
   input wire logic o_go_local // local pulse
);
   // command classes
   wire qry = i_cmd inside {ies_pkg::CMD_ERR_Q, ies_pkg::CMD_ESR_Q, ies_pkg::CMD_LEG_Q, ies_pkg::CMD_ESE_Q,
      ies_pkg::CMD_SRE_Q, ies_pkg::CMD_STB_Q, ies_pkg::CMD_TST_Q, ies_pkg::CMD_MCE_Q};
   wire gonly = !(i_cmd inside {ies_pkg::CMD_CLEAR, ies_pkg::CMD_ERR_Q, ies_pkg::CMD_ESR_Q, ies_pkg::CMD_LEG_Q});
   wire acc = i_cmd_valid && !i_tx_busy && i_cmd_gpib;

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_err_sets_ind: assert property (i_err_valid && i_err_code inside {[4'h1:4'ha]} |=> o_err_indicate)
      else $error("indication missing after error");
   a_srq_is_mss: assert property (o_srq == o_stb[6])
      else $error("srq differs from summary bit");
   a_stb_layout: assert property (o_stb[3:1] == 3'h0 && !o_stb[7] && o_stb[4] == i_rsp_ready)
      else $error("status byte layout wrong");
   a_mss_has_src: assert property (o_stb[6] |-> (o_stb[0] || o_stb[4] || o_stb[5]))
      else $error("summary bit without source");
   a_rsp_from_query: assert property (o_rsp_valid |-> $past(i_cmd_valid && qry && !i_tx_busy))
      else $error("answer without accepted query");
   a_tst_zero: assert property (acc && i_cmd == ies_pkg::CMD_TST_Q |=> o_rsp_valid && o_rsp_data == 8'h00)
      else $error("self test answer wrong");
   a_leg_gpib_one: assert property (acc && i_cmd == ies_pkg::CMD_LEG_Q |=> o_rsp_valid && o_rsp_data == 8'h01)
      else $error("legacy gpib answer wrong");
   a_clear_pulses: assert property (i_cmd_valid && i_cmd == ies_pkg::CMD_CLEAR && !i_err_valid
      |=> o_tx_flush && o_go_local && !o_err_indicate)
      else $error("clear effects missing");
   a_busy_drop: assert property (i_cmd_valid && qry && i_tx_busy |=> !o_rsp_valid && o_err_indicate)
      else $error("busy query not refused");
   a_nongpib_refused: assert property (i_cmd_valid && gonly && !i_cmd_gpib |=> !o_rsp_valid && o_err_indicate)
      else $error("gpib only command not refused");
   a_drop_clears: assert property (i_link_drop && !i_err_valid && !i_cmd_valid |=> !o_err_indicate)
      else $error("link drop left error");

   c_srq: cover property (o_srq);
   c_back_rsp: cover property (o_rsp_valid ##1 o_rsp_valid);
   c_flush: cover property (o_tx_flush);
endmodule : ies_regs_checker

bind ies_regs ies_regs_checker #(.MC_W(MC_W)) i_ies_regs_checker (.*);

// ---- tb/ies_host.sv ----
`timescale 1ns/1ns
module ies_host (
   input wire logic i_clk, // clock
   input wire logic i_rsp_valid, // answer strobe
   input wire logic [7:0] i_rsp_data, // answer
   output ies_pkg::ies_cmd_t o_cmd, // command
   output logic o_cmd_valid, // cmd strobe
   output logic [7:0] o_arg, // argument
   output logic o_gpib, // via gpib
   output logic o_err_valid, // err strobe
   output logic [3:0] o_err_code, // err code
   output logic o_err_gpib // err via gpib
);
   // idle bus at time zero
   initial begin
      o_cmd = ies_pkg::CMD_WAIT;
      o_cmd_valid = 1'b0;
      o_arg = 8'h00;
      o_gpib = 1'b0;
      o_err_valid = 1'b0;
      o_err_code = 4'h0;
      o_err_gpib = 1'b0;
   end

   // one command a call, queries never combined; set values 0..255
   task automatic send(input ies_pkg::ies_cmd_t c, input logic [7:0] a, input logic g,
      output logic got, output logic [7:0] d);
      @(posedge i_clk) #1;
      o_cmd_valid = 1'b1;
      o_cmd = c;
      o_arg = a;
      o_gpib = g;
      @(posedge i_clk) #1;
      o_cmd_valid = 1'b0;
      o_arg = ~a;
      got = i_rsp_valid;
      d = i_rsp_data;
   endtask : send

   // one parser error strobe
   task automatic err(input logic [3:0] c, input logic g);
      @(posedge i_clk) #1;
      o_err_valid = 1'b1;
      o_err_code = c;
      o_err_gpib = g;
      @(posedge i_clk) #1;
      o_err_valid = 1'b0;
      o_err_code = ~c;
   endtask : err
endmodule : ies_host

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_cmd_valid, i_cmd_gpib, i_err_valid, i_err_gpib;
   ies_pkg::ies_cmd_t i_cmd;
   logic [7:0] i_cmd_arg;
   logic [3:0] i_err_code;
   logic i_tx_busy = 1'b0;
   logic i_link_drop = 1'b0;
   logic i_gpib_en = 1'b0;
   logic [7:0] i_mcr = 8'h00;
   logic i_rsp_ready = 1'b0;
   logic o_rsp_valid, o_err_indicate, o_srq, o_tx_flush, o_go_local;
   logic [7:0] o_rsp_data, o_stb;
   int miscompares = 0;
   int n_checks = 0;
   logic got;
   logic [7:0] d, e, s, m, x;

   always #50 i_clk = ~i_clk;

   ies_regs i_ies_regs (.*);
   ies_host i_ies_host (.i_clk(i_clk), .i_rsp_valid(o_rsp_valid), .i_rsp_data(o_rsp_data), .o_cmd(i_cmd),
      .o_cmd_valid(i_cmd_valid), .o_arg(i_cmd_arg), .o_gpib(i_cmd_gpib), .o_err_valid(i_err_valid),
      .o_err_code(i_err_code), .o_err_gpib(i_err_gpib));

   // event status bit for an error code
   function automatic logic [7:0] esr_exp(input logic [3:0] c, input logic g);
      if (!g)
         return (c == 4'h9) ? 8'h02 : 8'h01;
      if (c inside {4'h8, 4'h9})
         return 8'h08;
      return (c inside {4'h1, 4'h2, 4'h3, 4'ha}) ? 8'h10 : 8'h20;
   endfunction : esr_exp

   // legacy flags after one non-gpib error, b0 gone once any error is seen
   function automatic logic [7:0] leg_exp(input logic [3:0] c);
      case (c)
         4'h5, 4'h6: return 8'h02;
         4'h3, 4'h4: return 8'h04;
         4'h2: return 8'h08;
         4'h9: return 8'h10;
         4'ha: return 8'h20;
         4'h7: return 8'h40;
         default: return 8'h00;
      endcase
   endfunction : leg_exp

   // status byte from its sources
   function automatic logic [7:0] stb_exp(input logic [7:0] mc, measurement_condition_enable, esr_ese, service_request_enable, input logic rdy);
      logic [7:0] r;
      r = {2'h0, |esr_ese, rdy, 3'h0, |(mc & measurement_condition_enable)};
      r[6] = |(r & service_request_enable & 8'h31);
      return r;
   endfunction : stb_exp

   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] sn);
      n_checks++;
      if (sn !== ex) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, ex, sn);
      end
   endtask : chk

   // query and compare its answer
   task automatic q(input ies_pkg::ies_cmd_t c, input logic g, input logic [7:0] ex);
      i_ies_host.send(c, 8'h00, g, got, d);
      chk("rsp_valid", 8'h01, {7'h00, got});
      chk(c.name(), ex, d);
   endtask : q

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   // run limit
   initial begin
      #5000000;
      miscompares++;
      conclude();
   end

   initial begin
      void'($urandom(40627));
      repeat (4) @(posedge i_clk);
      #1 i_rst_n = 1'b1;
      q(ies_pkg::CMD_ESR_Q, 1'b1, ies_pkg::ESR_RST);
      q(ies_pkg::CMD_ESE_Q, 1'b1, 8'h00);
      q(ies_pkg::CMD_SRE_Q, 1'b1, 8'h00);
      q(ies_pkg::CMD_MCE_Q, 1'b1, 8'h00);
      q(ies_pkg::CMD_ERR_Q, 1'b0, 8'h00);
      q(ies_pkg::CMD_LEG_Q, 1'b0, 8'h01);
      $display("test reset done");
      // random errors, highest kept, cleared by reading
      m = 8'h00;
      repeat (20) begin
         e = 8'($urandom_range(10, 1));
         m = (e > m) ? e : m;
         i_ies_host.err(e[3:0], 1'($urandom));
         chk("err_indicate", 8'h01, {7'h00, o_err_indicate});
      end
      i_ies_host.err(4'h1, 1'b0);
      q(ies_pkg::CMD_ERR_Q, 1'b0, m);
      q(ies_pkg::CMD_ERR_Q, 1'b0, 8'h00);
      chk("err_indicate", 8'h00, {7'h00, o_err_indicate});
      i_ies_host.send(ies_pkg::CMD_CLEAR, 8'h00, 1'b0, got, d);
      $display("test highest error done");
      // every code through each format
      for (int c = 1; c <= 10; c++) begin
         i_ies_host.err(c[3:0], 1'b0);
         q(ies_pkg::CMD_ESR_Q, 1'b0, esr_exp(c[3:0], 1'b0));
         q(ies_pkg::CMD_LEG_Q, 1'b0, leg_exp(c[3:0]));
         i_ies_host.err(c[3:0], 1'b1);
         q(ies_pkg::CMD_ESR_Q, 1'b1, esr_exp(c[3:0], 1'b1));
         q(ies_pkg::CMD_LEG_Q, 1'b1, 8'h01);
         q(ies_pkg::CMD_ERR_Q, 1'b0, {4'h0, c[3:0]});
      end
      $display("test code mapping done");
      // enables, status byte and service request
      for (int i = 0; i < 8; i++) begin
         e = (i == 0) ? 8'hff : 8'($urandom);
         s = (i == 1) ? 8'h00 : 8'($urandom);
         m = 8'($urandom);
         i_mcr = 8'($urandom);
         i_rsp_ready = 1'($urandom);
         i_ies_host.send(ies_pkg::CMD_ESE_SET, e, 1'b1, got, d);
         i_ies_host.send(ies_pkg::CMD_SRE_SET, s, 1'b1, got, d);
         i_ies_host.send(ies_pkg::CMD_MCE_SET, m, 1'b1, got, d);
         q(ies_pkg::CMD_ESE_Q, 1'b1, e);
         q(ies_pkg::CMD_SRE_Q, 1'b1, s);
         q(ies_pkg::CMD_MCE_Q, 1'b1, m);
         i_ies_host.send(ies_pkg::CMD_OPC_SET, 8'h00, 1'b1, got, d);
         x = stb_exp(i_mcr, m, e & 8'h01, s, i_rsp_ready);
         chk("stb", x, o_stb);
         chk("srq", {7'h00, x[6]}, {7'h00, o_srq});
         q(ies_pkg::CMD_STB_Q, 1'b1, x);
         q(ies_pkg::CMD_ESR_Q, 1'b1, 8'h01);
      end
      $display("test enables done");
      // power-on bit, wait, refusal, overrun, self test
      i_gpib_en = 1'b1;
      q(ies_pkg::CMD_ESR_Q, 1'b1, 8'h80);
      i_ies_host.send(ies_pkg::CMD_WAIT, 8'h00, 1'b1, got, d);
      chk("wait_rsp", 8'h00, {7'h00, got});
      q(ies_pkg::CMD_ERR_Q, 1'b0, 8'h00);
      i_ies_host.send(ies_pkg::CMD_WAIT, 8'h00, 1'b0, got, d);
      q(ies_pkg::CMD_ERR_Q, 1'b0, 8'h07);
      i_tx_busy = 1'b1;
      i_ies_host.send(ies_pkg::CMD_ESR_Q, 8'h00, 1'b1, got, d);
      chk("busy_rsp", 8'h00, {7'h00, got});
      i_tx_busy = 1'b0;
      q(ies_pkg::CMD_ERR_Q, 1'b0, 8'h09);
      q(ies_pkg::CMD_ESR_Q, 1'b1, esr_exp(4'h7, 1'b0) | esr_exp(4'h9, 1'b1));
      q(ies_pkg::CMD_TST_Q, 1'b1, ies_pkg::TST_ANSWER);
      $display("test gpib commands done");
      // link drop, then interface clear
      i_ies_host.err(4'h5, 1'b0);
      i_link_drop = 1'b1;
      @(posedge i_clk) #1;
      i_link_drop = 1'b0;
      chk("err_indicate", 8'h00, {7'h00, o_err_indicate});
      i_ies_host.send(ies_pkg::CMD_ESE_SET, 8'h3c, 1'b1, got, d);
      i_ies_host.err(4'h3, 1'b0);
      i_ies_host.send(ies_pkg::CMD_CLEAR, 8'h00, 1'b0, got, d);
      chk("tx_flush", 8'h01, {7'h00, o_tx_flush});
      chk("go_local", 8'h01, {7'h00, o_go_local});
      q(ies_pkg::CMD_ESE_Q, 1'b1, 8'h00);
      q(ies_pkg::CMD_ERR_Q, 1'b0, 8'h00);
      q(ies_pkg::CMD_ESR_Q, 1'b1, 8'h00);
      q(ies_pkg::CMD_LEG_Q, 1'b0, 8'h01);
      $display("test clear done");
      conclude();
   end
endmodule : tb
